// file: logic/cpr_bank.sv
`timescale 1ns/1ps
module cpr_bank (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // write port with byte strobes
   input wire logic wr_en,
   input wire logic [3:0] wr_idx,
   input wire logic [3:0] wr_strb,
   input wire logic [31:0] wr_data,
   // hardware stack pointer adjust
   input wire logic sp_push,
   input wire logic sp_pop,
   // read port
   input wire logic [3:0] rd_idx,
   output logic [31:0] rd_data,
   output logic [31:0] sp_value
);
   logic [31:0] regs_q [16];

   // byte lanes give byte, word, long
   for (genvar i = 0; i < 16; i++) begin : g_reg
      always_ff @(posedge clk or negedge arst_n) begin
         if (!arst_n) begin
            regs_q[i] <= 32'h0000_0000;
         end else if (i == 15 && sp_push) begin
            // stacking wins over a plain write
            regs_q[i] <= regs_q[i] - 32'h0000_0004;
         end else if (i == 15 && sp_pop) begin
            regs_q[i] <= regs_q[i] + 32'h0000_0004;
         end else if (wr_en && wr_idx == 4'(i)) begin
            for (int b = 0; b < 4; b++) begin
               if (wr_strb[b]) begin
                  regs_q[i][8*b +: 8] <= wr_data[8*b +: 8];
               end
            end
         end
      end
   end

   assign rd_data = regs_q[rd_idx];
   assign sp_value = regs_q[15];
endmodule

// file: logic/cpr_core_privilege_regs.sv
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
package cpr_pkg;
   localparam logic [7:0] OFS_DATA0 = 8'h00;
   localparam logic [7:0] OFS_ADDR0 = 8'h20;
   localparam logic [7:0] OFS_COND = 8'h40;
   localparam logic [7:0] OFS_STATUS = 8'h44;
   localparam logic [7:0] OFS_VBASE = 8'h48;
   localparam logic [7:0] OFS_SRAMB = 8'h4c;
   localparam logic [7:0] OFS_PERIB = 8'h50;
   localparam logic [7:0] OFS_REGION0 = 8'h54;
   localparam logic [7:0] OFS_REGION1 = 8'h58;
   localparam logic [7:0] OFS_CACHE = 8'h5c;
   localparam logic [7:0] OFS_MACSTATE = 8'h60;
   localparam logic [7:0] OFS_MACSUM = 8'h64;
   localparam logic [7:0] OFS_MACMASK = 8'h68;
   localparam logic [7:0] OFS_EVENT = 8'h6c;
   localparam logic [7:0] OFS_CORESTAT = 8'h70;
   localparam int SUPER_BIT = 13;
   localparam int EV_ENTRY_BIT = 0;
   localparam int EV_RETURN_BIT = 1;
   localparam int EV_PRIV_BIT = 2;
   localparam int CS_SUPER_BIT = 0;
   localparam int CS_VIOL_BIT = 1;
   localparam int MAC_MASK_EN_BIT = 5;
   localparam int VBASE_LSB = 20;
   localparam logic [15:0] STATUS_RST = 16'h2000;
   localparam logic [31:0] VBASE_KEEP = 32'hfff0_0000;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam logic [1:0] RESP_DECERR = 2'b11;
endpackage

module cpr_core_privilege_regs (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // axi4-lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // level tag and resource bases
   output logic access_super,
   output logic [31:0] vector_table_addr,
   output logic [31:0] sram_base,
   output logic [31:0] periph_base,
   // multiply-accumulate operand address masking
   input wire logic [31:0] mac_addr_in,
   output logic [31:0] mac_addr_out,
   // exception activity
   output logic exc_taken,
   output logic priv_violation
);
   logic [7:0] awaddr_q;
   logic aw_full_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic w_full_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [1:0] rresp_q;
   logic [31:0] rdata_q;
   logic [15:0] status_q;
   logic [15:0] stacked_q;
   logic [31:0] vbase_q;
   logic [31:0] sramb_q;
   logic [31:0] perib_q;
   logic [31:0] region0_q;
   logic [31:0] region1_q;
   logic [31:0] cache_q;
   logic [31:0] macstate_q;
   logic [31:0] macsum_q;
   logic [31:0] macmask_q;
   logic viol_q;
   logic exc_q;
   logic [31:0] mac_addr_q;
   logic super_now;
   logic do_wr;
   logic do_rd;
   logic wr_bank;
   logic rd_bank;
   logic wr_super_only;
   logic rd_super_only;
   logic wr_known;
   logic rd_known;
   logic wr_deny;
   logic rd_deny;
   logic ev_entry;
   logic ev_return;
   logic ev_priv;
   logic take_exc;
   logic leave_exc;
   logic [31:0] bank_rd;
   logic [31:0] wmask;
   logic [31:0] rd_mux;

   assign super_now = status_q[cpr_pkg::SUPER_BIT];
   assign access_super = super_now;

   // write channels taken in either order
   assign s_axi_awready = !aw_full_q && !bvalid_q;
   assign s_axi_wready = !w_full_q && !bvalid_q;
   assign do_wr = aw_full_q && w_full_q && !bvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign do_rd = s_axi_arvalid && s_axi_arready;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         aw_full_q <= 1'b0;
         awaddr_q <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_full_q <= 1'b1;
         awaddr_q <= s_axi_awaddr;
      end else if (do_wr) begin
         aw_full_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         w_full_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_full_q <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end else if (do_wr) begin
         w_full_q <= 1'b0;
      end
   end

   for (genvar b = 0; b < 4; b++) begin : g_mask
      assign wmask[8*b +: 8] = {8{wstrb_q[b]}};
   end

   // address decode
   assign wr_bank = awaddr_q[7:6] == 2'b00 && awaddr_q[1:0] == 2'b00;
   assign rd_bank = s_axi_araddr[7:6] == 2'b00 && s_axi_araddr[1:0] == 2'b00;

   function automatic logic is_super_reg(input logic [7:0] a);
      // configuration registers and the full status word
      is_super_reg = a == cpr_pkg::OFS_STATUS || a == cpr_pkg::OFS_VBASE || a == cpr_pkg::OFS_SRAMB ||
                     a == cpr_pkg::OFS_PERIB || a == cpr_pkg::OFS_REGION0 || a == cpr_pkg::OFS_REGION1 ||
                     a == cpr_pkg::OFS_CACHE;
   endfunction

   function automatic logic is_known(input logic [7:0] a);
      is_known = a[1:0] == 2'b00 && a <= cpr_pkg::OFS_CORESTAT;
   endfunction

   assign wr_super_only = is_super_reg(awaddr_q);
   assign rd_super_only = is_super_reg(s_axi_araddr);
   assign wr_known = is_known(awaddr_q);
   assign rd_known = is_known(s_axi_araddr);
   // user level limited to the subset
   assign wr_deny = do_wr && wr_known && wr_super_only && !super_now;
   assign rd_deny = do_rd && rd_known && rd_super_only && !super_now;

   // event register strobes
   assign ev_entry = do_wr && awaddr_q == cpr_pkg::OFS_EVENT && wstrb_q[0] && wdata_q[cpr_pkg::EV_ENTRY_BIT];
   assign ev_return = do_wr && awaddr_q == cpr_pkg::OFS_EVENT && wstrb_q[0] && wdata_q[cpr_pkg::EV_RETURN_BIT];
   assign ev_priv = do_wr && awaddr_q == cpr_pkg::OFS_EVENT && wstrb_q[0] && wdata_q[cpr_pkg::EV_PRIV_BIT];
   assign take_exc = ev_entry || wr_deny || rd_deny || ((ev_return || ev_priv) && !super_now);
   assign leave_exc = ev_return && super_now && !take_exc;

   cpr_bank u_bank (
      .clk(clk),
      .arst_n(arst_n),
      .wr_en(do_wr && wr_bank),
      .wr_idx(awaddr_q[5:2]),
      .wr_strb(wstrb_q),
      .wr_data(wdata_q),
      .sp_push(take_exc),
      .sp_pop(leave_exc),
      .rd_idx(s_axi_araddr[5:2]),
      .rd_data(bank_rd),
      .sp_value()
   );

   // status word and its stacked copy
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         status_q <= cpr_pkg::STATUS_RST;
         stacked_q <= cpr_pkg::STATUS_RST;
      end else if (take_exc) begin
         stacked_q <= status_q;
         status_q[cpr_pkg::SUPER_BIT] <= 1'b1;
      end else if (leave_exc) begin
         // restored flag may drop to user
         status_q <= stacked_q;
      end else if (do_wr && awaddr_q == cpr_pkg::OFS_STATUS && super_now) begin
         // clear flag in the written word drops to user
         status_q <= (status_q & ~wmask[15:0]) | (wdata_q[15:0] & wmask[15:0]);
      end else if (do_wr && awaddr_q == cpr_pkg::OFS_COND && wstrb_q[0]) begin
         // flag byte is the status low byte
         status_q[7:0] <= wdata_q[7:0];
      end
   end

   // supervisor configuration registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         vbase_q <= 32'h0000_0000;
         sramb_q <= 32'h0000_0000;
         perib_q <= 32'h0000_0000;
         region0_q <= 32'h0000_0000;
         region1_q <= 32'h0000_0000;
         cache_q <= 32'h0000_0000;
      end else if (do_wr && super_now) begin
         unique case (awaddr_q)
            // low 20 bits forced to zero
            cpr_pkg::OFS_VBASE: vbase_q <= ((vbase_q & ~wmask) | (wdata_q & wmask)) & cpr_pkg::VBASE_KEEP;
            cpr_pkg::OFS_SRAMB: sramb_q <= (sramb_q & ~wmask) | (wdata_q & wmask);
            cpr_pkg::OFS_PERIB: perib_q <= (perib_q & ~wmask) | (wdata_q & wmask);
            cpr_pkg::OFS_REGION0: region0_q <= (region0_q & ~wmask) | (wdata_q & wmask);
            cpr_pkg::OFS_REGION1: region1_q <= (region1_q & ~wmask) | (wdata_q & wmask);
            cpr_pkg::OFS_CACHE: cache_q <= (cache_q & ~wmask) | (wdata_q & wmask);
            default: ;
         endcase
      end
   end

   // user-level multiply-accumulate registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         macstate_q <= 32'h0000_0000;
         macsum_q <= 32'h0000_0000;
         macmask_q <= 32'h0000_0000;
      end else if (do_wr) begin
         unique case (awaddr_q)
            cpr_pkg::OFS_MACSTATE: macstate_q <= (macstate_q & ~wmask) | (wdata_q & wmask);
            cpr_pkg::OFS_MACSUM: macsum_q <= (macsum_q & ~wmask) | (wdata_q & wmask);
            cpr_pkg::OFS_MACMASK: macmask_q <= (macmask_q & ~wmask) | (wdata_q & wmask);
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mac_addr_q <= 32'h0000_0000;
      end else if (macstate_q[cpr_pkg::MAC_MASK_EN_BIT]) begin
         mac_addr_q <= mac_addr_in & macmask_q;
      end else begin
         mac_addr_q <= mac_addr_in;
      end
   end

   // sticky violation, a new one wins over the clear
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         viol_q <= 1'b0;
      end else if (wr_deny || rd_deny || ((ev_return || ev_priv) && !super_now)) begin
         viol_q <= 1'b1;
      end else if (do_wr && awaddr_q == cpr_pkg::OFS_CORESTAT && wstrb_q[0] && wdata_q[cpr_pkg::CS_VIOL_BIT]) begin
         viol_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         exc_q <= 1'b0;
      end else begin
         exc_q <= take_exc;
      end
   end

   // write response
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bvalid_q <= 1'b0;
         bresp_q <= cpr_pkg::RESP_OKAY;
      end else if (do_wr) begin
         bvalid_q <= 1'b1;
         bresp_q <= !wr_known ? cpr_pkg::RESP_DECERR : (wr_deny ? cpr_pkg::RESP_SLVERR : cpr_pkg::RESP_OKAY);
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // read mux, denied reads return zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (rd_bank) begin
         rd_mux = bank_rd;
      end else begin
         unique case (s_axi_araddr)
            cpr_pkg::OFS_COND: rd_mux = {24'h000000, status_q[7:0]};
            cpr_pkg::OFS_STATUS: rd_mux = {16'h0000, status_q};
            cpr_pkg::OFS_VBASE: rd_mux = vbase_q;
            cpr_pkg::OFS_SRAMB: rd_mux = sramb_q;
            cpr_pkg::OFS_PERIB: rd_mux = perib_q;
            cpr_pkg::OFS_REGION0: rd_mux = region0_q;
            cpr_pkg::OFS_REGION1: rd_mux = region1_q;
            cpr_pkg::OFS_CACHE: rd_mux = cache_q;
            cpr_pkg::OFS_MACSTATE: rd_mux = macstate_q;
            cpr_pkg::OFS_MACSUM: rd_mux = macsum_q;
            cpr_pkg::OFS_MACMASK: rd_mux = macmask_q;
            cpr_pkg::OFS_CORESTAT: rd_mux = {30'h0, viol_q, super_now};
            default: rd_mux = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rvalid_q <= 1'b0;
         rresp_q <= cpr_pkg::RESP_OKAY;
         rdata_q <= 32'h0000_0000;
      end else if (do_rd) begin
         rvalid_q <= 1'b1;
         rresp_q <= !rd_known ? cpr_pkg::RESP_DECERR : (rd_deny ? cpr_pkg::RESP_SLVERR : cpr_pkg::RESP_OKAY);
         rdata_q <= (rd_deny || !rd_known) ? 32'h0000_0000 : rd_mux;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;
   assign vector_table_addr = vbase_q;
   assign sram_base = sramb_q;
   assign periph_base = perib_q;
   assign mac_addr_out = mac_addr_q;
   assign exc_taken = exc_q;
   assign priv_violation = viol_q;
endmodule

// file: verif/cpr_core_privilege_regs_sva.sv
`timescale 1ns/1ps
module cpr_core_privilege_regs_sva (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // register bus
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // level and exceptions
   input wire logic access_super,
   input wire logic [31:0] vector_table_addr,
   input wire logic exc_taken,
   input wire logic priv_violation
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("bresp dropped early");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
   property p_w_block;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_w_block: assert property (p_w_block) else $error("write taken during response");
   property p_vbase_low;
      vector_table_addr[19:0] == 20'h0;
   endproperty
   a_vbase_low: assert property (p_vbase_low) else $error("vector base low bits set");
   property p_err_zero;
      s_axi_rvalid && s_axi_rresp[1] |-> s_axi_rdata == 32'h0;
   endproperty
   a_err_zero: assert property (p_err_zero) else $error("refused read leaks data");
   property p_enter_super;
      $rose(access_super) |-> ##[0:1] exc_taken;
   endproperty
   a_enter_super: assert property (p_enter_super) else $error("level rose without exception");
   property p_exc_super;
      exc_taken |-> access_super && !$past(exc_taken);
   endproperty
   a_exc_super: assert property (p_exc_super) else $error("exception not at supervisor");
   property p_viol_super;
      $rose(priv_violation) |-> access_super;
   endproperty
   a_viol_super: assert property (p_viol_super) else $error("violation left user level");
   property p_drop_by_write;
      $fell(access_super) |-> $rose(s_axi_bvalid);
   endproperty
   a_drop_by_write: assert property (p_drop_by_write) else $error("level fell without write");
   property p_viol_sticky;
      $fell(priv_violation) |-> $rose(s_axi_bvalid);
   endproperty
   a_viol_sticky: assert property (p_viol_sticky) else $error("violation flag lost");
endmodule
bind cpr_core_privilege_regs cpr_core_privilege_regs_sva i_sva (
   .clk(clk), .arst_n(arst_n), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .access_super(access_super),
   .vector_table_addr(vector_table_addr), .exc_taken(exc_taken), .priv_violation(priv_violation)
);

// file: verif/cpr_core_privilege_regs_tb.sv
`timescale 1ns/1ps
module cpr_core_privilege_regs_tb;
   logic clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, access_super, exc_taken, priv_violation;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_wdata, s_axi_rdata, vector_table_addr, sram_base, periph_base, mac_addr_in, mac_addr_out;
   logic [31:0] mirror [16];
   int errors, checks, exc_cnt;
   int seed = 32'h9c37;

   cpr_core_privilege_regs i_dut (
      .clk(clk), .arst_n(arst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .access_super(access_super), .vector_table_addr(vector_table_addr), .sram_base(sram_base),
      .periph_base(periph_base), .mac_addr_in(mac_addr_in), .mac_addr_out(mac_addr_out),
      .exc_taken(exc_taken), .priv_violation(priv_violation)
   );

   initial clk = 1'h0;
   always #25 clk = ~clk;
   // counted off the edge so the pulse is never missed
   always @(negedge clk) if (exc_taken === 1'h1) exc_cnt++;

   task automatic print_verdict();
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk_data(input logic [31:0] g, input logic [31:0] w);
      checks++;
      if (g !== w) begin
         errors++;
         $display("ERROR %0t data %h want %h", $time, g, w);
      end
   endtask
   task automatic chk_resp(input logic [1:0] g, input logic [1:0] w);
      checks++;
      if (g !== w) begin
         errors++;
         $display("ERROR %0t resp %h want %h", $time, g, w);
      end
   endtask
   task automatic chk_bit(input logic g, input logic w);
      checks++;
      if (g !== w) begin
         errors++;
         $display("ERROR %0t flag %b want %b", $time, g, w);
      end
   endtask
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
      for (int b = 0; b < 4; b++)
         if (s[b]) o[b*8 +: 8] = n[b*8 +: 8];
      return o;
   endfunction
   // address and data offered together, each released once taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
      logic aw_d, w_d, aw_t, w_t, hs;
      aw_d = 1'h0;
      w_d = 1'h0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      do begin
         @(negedge clk);
         aw_t = s_axi_awvalid && s_axi_awready;
         w_t = s_axi_wvalid && s_axi_wready;
         @(posedge clk);
         if (aw_t) s_axi_awvalid <= 1'h0;
         if (w_t) s_axi_wvalid <= 1'h0;
         aw_d = aw_d || aw_t;
         w_d = w_d || w_t;
      end while (!(aw_d && w_d));
      // late ready makes the response stand
      repeat ($unsigned($random(seed)) % 3) @(posedge clk);
      s_axi_bready <= 1'h1;
      do begin
         @(negedge clk);
         hs = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge clk);
      end while (!hs);
      s_axi_bready <= 1'h0;
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic hs;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do begin
         @(negedge clk);
         hs = s_axi_arready;
         @(posedge clk);
      end while (!hs);
      s_axi_arvalid <= 1'h0;
      repeat ($unsigned($random(seed)) % 3) @(posedge clk);
      s_axi_rready <= 1'h1;
      do begin
         @(negedge clk);
         hs = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge clk);
      end while (!hs);
      s_axi_rready <= 1'h0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf,
                     input logic [1:0] er = cpr_pkg::RESP_OKAY);
      logic [1:0] r;
      axi_wr(a, d, s, r);
      chk_resp(r, er);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = cpr_pkg::RESP_OKAY);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(a, d, r);
      chk_data(d, ed);
      chk_resp(r, er);
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      $display("ERROR %0t watchdog expired", $time);
      print_verdict();
   end

   initial begin
      logic [31:0] v;
      logic [31:0] vals [7];
      logic [7:0] sofs [7];
      logic [3:0] s;
      int i;
      int n;
      sofs = '{cpr_pkg::OFS_SRAMB, cpr_pkg::OFS_PERIB, cpr_pkg::OFS_REGION0, cpr_pkg::OFS_REGION1,
               cpr_pkg::OFS_CACHE, cpr_pkg::OFS_MACSUM, cpr_pkg::OFS_MACMASK};
      arst_n = 1'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata, mac_addr_in} = '0;
      mirror = '{default: 32'h0};
      repeat (16) @(posedge clk);
      arst_n <= 1'h1;
      @(posedge clk);
      rd(cpr_pkg::OFS_STATUS, 32'h0000_2000);
      chk_bit(access_super, 1'h1);
      for (int k = 0; k < 40; k++) begin
         i = $unsigned($random(seed)) % 16;
         v = $random(seed);
         s = (k < 2) ? 4'hf : 4'($random(seed));
         mirror[i] = merge(mirror[i], v, s);
         wr(8'(i * 4), v, s);
         rd(8'(i * 4), mirror[i]);
      end
      for (int k = 0; k < 7; k++) begin
         vals[k] = $random(seed);
         wr(sofs[k], vals[k]);
         rd(sofs[k], vals[k]);
      end
      chk_data(sram_base, vals[0]);
      chk_data(periph_base, vals[1]);
      v = $random(seed) | 32'h000f_ffff;
      wr(cpr_pkg::OFS_VBASE, v);
      rd(cpr_pkg::OFS_VBASE, v & 32'hfff0_0000);
      chk_data(vector_table_addr, v & 32'hfff0_0000);
      wr(cpr_pkg::OFS_COND, 32'h0000_00a5, 4'h1);
      rd(cpr_pkg::OFS_STATUS, 32'h0000_20a5);
      for (int e = 0; e < 2; e++) begin
         wr(cpr_pkg::OFS_MACSTATE, 32'(e) << cpr_pkg::MAC_MASK_EN_BIT);
         mac_addr_in <= $random(seed);
         @(posedge clk);
         @(negedge clk);
         chk_data(mac_addr_out, (e == 1) ? (mac_addr_in & vals[6]) : mac_addr_in);
         @(posedge clk);
      end
      wr(8'h3c, 32'h0000_1000);
      n = exc_cnt;
      wr(cpr_pkg::OFS_EVENT, 32'h1);
      rd(8'h3c, 32'h0000_0ffc);
      chk_data(32'(exc_cnt - n), 32'h1);
      wr(cpr_pkg::OFS_EVENT, 32'h2);
      rd(8'h3c, 32'h0000_1000);
      wr(cpr_pkg::OFS_STATUS, 32'h0000_0005, 4'h3);
      chk_bit(access_super, 1'h0);
      rd(8'h00, mirror[0]);
      wr(cpr_pkg::OFS_COND, 32'h0000_005a, 4'h1);
      n = exc_cnt;
      rd(cpr_pkg::OFS_VBASE, 32'h0, cpr_pkg::RESP_SLVERR);
      chk_bit(access_super, 1'h1);
      chk_bit(priv_violation, 1'h1);
      rd(cpr_pkg::OFS_CORESTAT, 32'h3);
      wr(cpr_pkg::OFS_EVENT, 32'h2);
      chk_bit(access_super, 1'h0);
      wr(cpr_pkg::OFS_VBASE, 32'h0, 4'hf, cpr_pkg::RESP_SLVERR);
      rd(cpr_pkg::OFS_VBASE, v & 32'hfff0_0000);
      wr(cpr_pkg::OFS_EVENT, 32'h2);
      wr(cpr_pkg::OFS_EVENT, 32'h4);
      chk_bit(access_super, 1'h1);
      chk_data(32'(exc_cnt - n), 32'h3);
      wr(cpr_pkg::OFS_CORESTAT, 32'h2);
      rd(cpr_pkg::OFS_CORESTAT, 32'h1);
      chk_bit(priv_violation, 1'h0);
      wr(cpr_pkg::OFS_EVENT, 32'h4);
      chk_bit(access_super, 1'h1);
      chk_bit(priv_violation, 1'h0);
      chk_data(32'(exc_cnt - n), 32'h3);
      wr(8'h80, 32'h1, 4'hf, cpr_pkg::RESP_DECERR);
      rd(8'h80, 32'h0, cpr_pkg::RESP_DECERR);
      print_verdict();
   end
endmodule
